// ===== design/zero_delay_and_pll_status_regs.sv
// zero-delay configuration register and pll status readback register
// How it works
// - bits 4:3 of the zero-delay config pick the channel divider feeding external zero-delay feedback.
// - the divider select code maps to dividers 0..3 in binary order, code 0 after reset.
// - enable set with mode bit clear gives internal zero-delay mode; mode bit clears at reset.
// - enable set with mode bit set gives external zero-delay mode using the selected divider.
// - enable clear turns zero delay off, and enable resets to zero.
// - status bit 6 reads one once vco calibration is finished.
// - status bit 5 shows the holdover state itself, not whether holdover is enabled.
// - status bit 4 reads one when the second reference feeds the pll, zero for the first.
// - status bit 3 reads one while the vco is above its monitor threshold.
// - status bit 2 reads one while the second reference is above its selected threshold.
// - status bit 1 reads one while the first reference is above its selected threshold.
`timescale 1ns/10ps
module zero_delay_and_pll_status_regs
   import zd_status_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire reg_req_t i_req,
   input wire pll_state_t i_pll_state,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output zd_mode_t o_zd_mode,
   output logic [3:0] o_fb_div_onehot,
   output logic [1:0] o_fb_div_sel
);
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic [7:0] rdata_q;
   logic rvalid_q;
   zd_mode_t mode_q;
   logic [3:0] onehot_q;
   logic [1:0] fbsel_q;
   pll_state_t flags;
   logic [7:0] status_word;

   wire hit_cfg = i_req.addr == ZERO_DELAY_CONFIG_ADDR;
   wire hit_sts = i_req.addr == PLL_STATUS_READBACK_ADDR;
   // status writes fall through untouched
   wire wr_cfg = i_req.wr && hit_cfg;

   zd_status_capture #(
      .WIDTH(6)
   ) u_capture (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_flags(i_pll_state),
      .o_flags(flags)
   );

   // each flag lands on its own status bit; bits 7 and 0 stay zero
   always_comb begin
      status_word = 8'h00;
      status_word[VCO_CAL_BIT] = flags.vco_cal_done;
      status_word[HOLDOVER_BIT] = flags.holdover_active;
      status_word[REF_SEL_BIT] = flags.second_reference_input_sel;
      status_word[VCO_OVER_BIT] = flags.vco_over_thresh;
      status_word[SECOND_REF_OVER_BIT] = flags.second_reference_input_over;
      status_word[FIRST_REF_OVER_BIT] = flags.first_reference_input_over;
   end

   wire [7:0] rd_mux = hit_cfg ? (cfg_q & ZERO_DELAY_CONFIG_MASK)
                     : hit_sts ? (status_word & PLL_STATUS_MASK) : 8'h00;
   wire [7:0] rdata_d = i_req.rd ? rd_mux : rdata_q;
   wire [1:0] fbsel = cfg_q[FB_SEL_LSB+1:FB_SEL_LSB];
   wire zd_en = cfg_q[ZD_EN_BIT];
   wire ext = cfg_q[EXT_MODE_BIT];
   // off dominates; mode bit only matters while enabled
   wire zd_mode_t mode_d = !zd_en ? ZD_OFF : (ext ? ZD_EXTERNAL : ZD_INTERNAL);
   // feedback divider only drives in external mode, avoids a stray path
   wire [3:0] onehot_d = (mode_d == ZD_EXTERNAL) ? (4'h1 << fbsel) : 4'h0;

   assign cfg_d = wr_cfg ? (i_req.wdata & ZERO_DELAY_CONFIG_MASK) : cfg_q;

   // config register, masked on write so unused bits can never be set
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= ZERO_DELAY_CONFIG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // read data holds between reads, valid is a one-cycle pulse
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= i_req.rd;
      end
   end

   // mode outputs lag the config by one flop so they never glitch
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= ZD_OFF;
         onehot_q <= 4'h0;
         fbsel_q <= 2'h0;
      end else begin
         mode_q <= mode_d;
         onehot_q <= onehot_d;
         fbsel_q <= fbsel;
      end
   end

   assign o_rdata = rdata_q;
   assign o_rvalid = rvalid_q;
   assign o_zd_mode = mode_q;
   assign o_fb_div_onehot = onehot_q;
   assign o_fb_div_sel = fbsel_q;

   a_cfg_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      wr_cfg |=> cfg_q == ($past(i_req.wdata) & ZERO_DELAY_CONFIG_MASK))
      else $error("config write not stored");

   a_status_ro: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.wr && hit_sts) |=> $stable(cfg_q))
      else $error("status write changed config");

   a_mode_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !cfg_q[ZD_EN_BIT] |=> o_zd_mode == ZD_OFF && o_fb_div_onehot == 4'h0)
      else $error("zero delay not off");

   a_mode_int: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      cfg_q[ZD_EN_BIT] && !cfg_q[EXT_MODE_BIT] |=> o_zd_mode == ZD_INTERNAL)
      else $error("internal mode missed");

   a_mode_ext: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      cfg_q[ZD_EN_BIT] && cfg_q[EXT_MODE_BIT] |=> o_zd_mode == ZD_EXTERNAL)
      else $error("external mode missed");

   a_fb_divider: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode == ZD_EXTERNAL |-> o_fb_div_onehot == (4'h1 << o_fb_div_sel))
      else $error("wrong feedback divider");

   // the capture stage is cleared by reset, so a read right after release is skipped
   a_vco_cal_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[VCO_CAL_BIT] == $past(i_pll_state.vco_cal_done, 2))
      else $error("vco cal flag wrong");

   a_first_ref_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[FIRST_REF_OVER_BIT] == $past(i_pll_state.first_reference_input_over, 2))
      else $error("first reference flag wrong");

   a_holdover_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[HOLDOVER_BIT] == $past(i_pll_state.holdover_active, 2))
      else $error("holdover flag wrong");

   a_ref_sel_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[REF_SEL_BIT] == $past(i_pll_state.second_reference_input_sel, 2))
      else $error("reference select flag wrong");

   a_vco_over_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[VCO_OVER_BIT] == $past(i_pll_state.vco_over_thresh, 2))
      else $error("vco threshold flag wrong");

   a_second_ref_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_sts && $past(i_rst_n))
      |=> o_rdata[SECOND_REF_OVER_BIT] == $past(i_pll_state.second_reference_input_over, 2))
      else $error("second reference flag wrong");

   a_unused_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_rvalid |-> o_rdata[7] == 1'b0 && o_rdata[0] == 1'b0)
      else $error("unused bit set");

   a_cfg_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && hit_cfg)
      |=> o_rdata == ($past(cfg_q) & ZERO_DELAY_CONFIG_MASK))
      else $error("config readback wrong");

   a_other_addr_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && !hit_cfg && !hit_sts)
      |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_read_no_effect: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_req.rd && !i_req.wr)
      |=> $stable(cfg_q))
      else $error("read changed config");

   a_rvalid_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1
      |=> o_rvalid == $past(i_req.rd))
      else $error("read valid not a pulse");

   a_rdata_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_req.rd
      |=> $stable(o_rdata))
      else $error("read data moved without a read");

   a_no_stray_feedback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode != ZD_EXTERNAL
      |-> o_fb_div_onehot == 4'h0)
      else $error("feedback divider outside external mode");

   a_fb_code_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode == ZD_EXTERNAL && o_fb_div_sel == 2'h0
      |-> o_fb_div_onehot == 4'h1)
      else $error("code zero not divider zero");

   a_fb_code_three: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode == ZD_EXTERNAL && o_fb_div_sel == 2'h3
      |-> o_fb_div_onehot == 4'h8)
      else $error("code three not divider three");

   a_one_divider: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode == ZD_EXTERNAL
      |-> $onehot(o_fb_div_onehot))
      else $error("not exactly one feedback divider");

   a_sel_tracks_cfg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      1'b1
      |=> o_fb_div_sel == $past(cfg_q[FB_SEL_LSB+1:FB_SEL_LSB]))
      else $error("divider select not following config");

   a_on_needs_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_zd_mode != ZD_OFF
      |-> $past(cfg_q[ZD_EN_BIT]))
      else $error("zero delay on without enable");

   a_reset_state: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(i_rst_n)
      |-> o_zd_mode == ZD_OFF && !o_rvalid && cfg_q == ZERO_DELAY_CONFIG_RESET)
      else $error("state after reset wrong");
endmodule : zero_delay_and_pll_status_regs

// ===== design/zd_status_pkg.sv
// package: offsets, field positions, reset values and carriers for the zero-delay and pll status registers
package zd_status_pkg;
   localparam logic [9:0] ZERO_DELAY_CONFIG_ADDR = 10'h01E;
   localparam logic [9:0] PLL_STATUS_READBACK_ADDR = 10'h01F;
   localparam int FB_SEL_LSB = 3;
   localparam int EXT_MODE_BIT = 2;
   localparam int ZD_EN_BIT = 1;
   localparam int VCO_CAL_BIT = 6;
   localparam int HOLDOVER_BIT = 5;
   localparam int REF_SEL_BIT = 4;
   localparam int VCO_OVER_BIT = 3;
   localparam int SECOND_REF_OVER_BIT = 2;
   localparam int FIRST_REF_OVER_BIT = 1;
   localparam logic [7:0] ZERO_DELAY_CONFIG_RESET = 8'h00;
   localparam logic [7:0] ZERO_DELAY_CONFIG_MASK = 8'h1E;
   localparam logic [7:0] PLL_STATUS_MASK = 8'h7E;

   typedef enum logic [1:0] {
      ZD_OFF,
      ZD_INTERNAL,
      ZD_EXTERNAL
   } zd_mode_t;

   // live pll state sampled into the readback register
   typedef struct packed {
      logic vco_cal_done;
      logic holdover_active;
      logic second_reference_input_sel;
      logic vco_over_thresh;
      logic second_reference_input_over;
      logic first_reference_input_over;
   } pll_state_t;

   // register access from the serial control port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : zd_status_pkg

// ===== design/zd_status_capture.sv
// status flag capture: one synchronous stage per flag
`timescale 1ns/10ps
module zd_status_capture #(
   parameter int WIDTH = 6
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [WIDTH-1:0] i_flags,
   output logic [WIDTH-1:0] o_flags
);
   logic [WIDTH-1:0] flags_q;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) flags_q <= '0;
      else flags_q <= i_flags;
   end

   assign o_flags = flags_q;
endmodule : zd_status_capture

// ===== tb/zero_delay_and_pll_status_regs_tb.sv
// self-checking bench for the zero-delay config and pll status registers
`timescale 1ns/10ps
module zero_delay_and_pll_status_regs_tb;
   import zd_status_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   reg_req_t i_req = '0;
   pll_state_t i_pll_state = '0;
   logic [7:0] o_rdata;
   logic o_rvalid;
   zd_mode_t o_zd_mode;
   logic [3:0] o_fb_div_onehot;
   logic [1:0] o_fb_div_sel;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   always #2.5 i_sys_clk = ~i_sys_clk;
   zero_delay_and_pll_status_regs uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req),
      .i_pll_state(i_pll_state), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_zd_mode(o_zd_mode),
      .o_fb_div_onehot(o_fb_div_onehot), .o_fb_div_sel(o_fb_div_sel));
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_mode(input zd_mode_t m, input logic [1:0] sel, input logic [3:0] oh);
      n_checks++;
      if (o_zd_mode !== m || o_fb_div_sel !== sel || o_fb_div_onehot !== oh) begin
         mismatches++;
         $display("MISMATCH %0t mode outputs %0d %h %h", $time, o_zd_mode, o_fb_div_sel, o_fb_div_onehot);
      end
   endtask : chk_mode
   // second edge wait lets the mode outputs settle after a config write
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      i_req.wr = 1'b1;
      i_req.addr = a;
      i_req.wdata = d;
      @(posedge i_sys_clk);
      #1 i_req.wr = 1'b0;
      @(posedge i_sys_clk);
      #1;
   endtask : wr
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      i_req.rd = 1'b1;
      i_req.addr = a;
      @(posedge i_sys_clk);
      #1 i_req.rd = 1'b0;
      chk({7'h00, o_rvalid}, 8'h01);
      chk(o_rdata, exp);
      @(posedge i_sys_clk);
      #1;
      chk({7'h00, o_rvalid}, 8'h00);
      chk(o_rdata, exp);
   endtask : rd
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles >= 2000) begin
         mismatches++;
         $display("MISMATCH %0t run did not finish", $time);
         final_report();
      end
   end
   initial begin
      repeat (3) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      rd(ZERO_DELAY_CONFIG_ADDR, ZERO_DELAY_CONFIG_RESET);
      chk_mode(ZD_OFF, 2'h0, 4'h0);
      for (int c = 0; c < 4; c++) begin
         // stray bits 7:5 and 0 set on purpose, they must drop
         wr(ZERO_DELAY_CONFIG_ADDR, 8'hE7 | (8'(c) << 3));
         chk_mode(ZD_EXTERNAL, 2'(c), 4'h1 << c);
         rd(ZERO_DELAY_CONFIG_ADDR, 8'h06 | (8'(c) << 3));
      end
      wr(ZERO_DELAY_CONFIG_ADDR, 8'h1A);
      chk_mode(ZD_INTERNAL, 2'h3, 4'h0);
      wr(ZERO_DELAY_CONFIG_ADDR, 8'h1C);
      chk_mode(ZD_OFF, 2'h3, 4'h0);
      for (int i = 0; i < 6; i++) begin
         i_pll_state = pll_state_t'(6'h01 << i);
         repeat (2) @(posedge i_sys_clk);
         #1 rd(PLL_STATUS_READBACK_ADDR, 8'h02 << i);
      end
      wr(PLL_STATUS_READBACK_ADDR, 8'hFF);
      rd(PLL_STATUS_READBACK_ADDR, 8'h40);
      rd(PLL_STATUS_READBACK_ADDR, 8'h40);
      rd(ZERO_DELAY_CONFIG_ADDR, 8'h1C);
      rd(10'h100, 8'h00);
      // mid-run reset must bring config and mode back to their reset state
      wr(ZERO_DELAY_CONFIG_ADDR, 8'h16);
      chk_mode(ZD_EXTERNAL, 2'h2, 4'h4);
      i_rst_n = 1'b0;
      repeat (3) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      rd(ZERO_DELAY_CONFIG_ADDR, ZERO_DELAY_CONFIG_RESET);
      chk_mode(ZD_OFF, 2'h0, 4'h0);
      rd(PLL_STATUS_READBACK_ADDR, 8'h40);
      final_report();
   end
endmodule : zero_delay_and_pll_status_regs_tb
